// >>> include/becp_pkg.sv
// Constants shared by the bit error comparator pair.
package becp_pkg;
	// Register offsets on the plain register port.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] CNT_A_OFS = 8'h04;
	localparam logic [7:0] CNT_B_OFS = 8'h08;
	// Control register field positions.
	localparam int DLY_LSB = 0;
	localparam int MODE_BIT = 4;
	localparam int BLEVEL_BIT = 5;
	localparam int BEXT_BIT = 6;
	// Control register reset values.
	localparam logic [3:0] DLY_RST = 4'h0;
	localparam logic MODE_RST = 1'b0;
	localparam logic BLEVEL_RST = 1'b0;
	localparam logic BEXT_RST = 1'b0;
	// Reference delay line lengths in bits.
	localparam int DLINE_LEN = 8;
	localparam int FIX_LEN = 4;
	localparam int VAR_LEN = 28;
	localparam int VAR_STEP = 4;
	// Error counter width.
	localparam int CNT_W = 16;
	// Positions of the synchronised pins in the pin vector.
	localparam int P_BCLK = 0;
	localparam int P_COUT = 1;
	localparam int P_CIN = 2;
	localparam int P_RX = 3;
	localparam int P_PCM = 4;
	localparam int P_SLOT = 5;
	localparam int P_EXT = 6;
	localparam int P_VSEL = 7;
	localparam int PIN_W = 10;
endpackage : becp_pkg

// >>> include/becp_dly_if.sv
// Interface joining the comparator to its variable reference delay.
`timescale 1ns/10ps
`default_nettype none
interface becp_dly_if;
	logic shift; // One-cycle pulse: advance the delay by one bit.
	logic din; // Reference bit entering the delay.
	logic [2:0] sel; // Delay in steps of four bits.
	logic dout; // Delayed reference bit.
	modport drv (output shift, output din, output sel, input dout);
	modport dly (input shift, input din, input sel, output dout);
endinterface : becp_dly_if
`default_nettype wire

// >>> src/becp_var_delay.sv
// Variable reference delay of zero to twenty-eight bits in four-bit steps.
`timescale 1ns/10ps
`default_nettype none
module becp_var_delay
	import becp_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	becp_dly_if.dly dif
);
	// All state of the delay: the shift chain and the registered tap.
	typedef struct packed {
		logic [VAR_LEN-1:0] sr;
		logic dout;
	} becp_vd_type;

	becp_vd_type st_reg; // Registered state.
	becp_vd_type st_next; // Next state.
	logic [4:0] tap_idx; // Chain stage that ends a delay of four times sel.

	// The tap is the last stage of the chosen number of four-bit groups.
	assign tap_idx = 5'({dif.sel, 2'b00} - 5'h01);
	assign dif.dout = st_reg.dout;

	// Shift on each bit strobe and pick the tap, or the input itself at zero delay.
	always_comb begin
		st_next = st_reg;
		if (dif.shift) begin
			st_next.sr = {st_reg.sr[VAR_LEN-2:0], dif.din};
		end
		if (dif.sel == 3'h0) begin
			st_next.dout = dif.din;
		end else begin
			st_next.dout = st_reg.sr[tap_idx];
		end
	end

	// State register.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// A four-bit setting reads the fourth stage of the chain.
	property p_var_tap;
		@(posedge clk) disable iff (reset)
		(dif.sel == 3'h1) |=> (dif.dout == $past(st_reg.sr[3]));
	endproperty
	a_var_tap: assert property (p_var_tap) else $error("variable delay tap wrong");
endmodule : becp_var_delay
`default_nettype wire

// >>> src/becp_top.sv
// Bit error comparator pair: delayed-reference comparator and constant-reference comparator.
//
// Contract
// - Reference delay zero to 7.5 bits, half-bit steps.
// - Eight-stage delay line on true or inverted clock.
// - Delay setting selects stage, half bits share stage.
// - Both inputs realigned on the complementary clock edge.
// - Comparator A errors divided by two.
// - Decoder-output mode: fixed, then 0-28 bit delay.
// - Mode picks coder output or delayed coder input.
// - Comparator B flags PCM bit mismatching constant level.
// - Comparator B accepts external reference stream instead.
// - Comparator B errors output undivided, one per mismatch.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module becp_top
	import becp_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic bit_clk,
	input wire logic coder_out,
	input wire logic coder_in,
	input wire logic rx_data,
	input wire logic pcm_bit,
	input wire logic pcm_slot,
	input wire logic ext_ref,
	input wire logic [2:0] vit_delay_sel,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic err_a_out,
	output logic err_b_out
);
	// All state of the comparator pair outside the variable delay.
	typedef struct packed {
		logic [PIN_W-1:0] s1; // First synchroniser stage.
		logic [PIN_W-1:0] s2; // Second synchroniser stage.
		logic clk_d; // Bit clock one cycle back, for edge detection.
		logic [3:0] dly_half; // Reference delay in half bits.
		logic decoder_delay_mode_switch; // Set selects decoder-output mode.
		logic b_level; // Constant reference level of comparator B.
		logic b_ext; // Comparator B uses the external reference.
		logic [FIX_LEN-1:0] fix_sr; // Fixed delay ahead of the delay line.
		logic [DLINE_LEN-1:0] dline; // Eight-stage reference delay line.
		logic ref_al; // Realigned reference bit.
		logic rx_al; // Realigned received bit.
		logic vld_a; // Realigned pair is ready for comparison.
		logic [1:0] div_a; // Error divider of comparator A.
		logic err_b; // Comparator B error pulse.
		logic [CNT_W-1:0] cnt_a; // Comparator A error count.
		logic [CNT_W-1:0] cnt_b; // Comparator B error count.
		logic [31:0] rdata; // Read data.
	} becp_st_type;

	becp_st_type st_reg; // Registered state.
	becp_st_type st_next; // Next state.
	logic rise; // Rising bit clock edge seen this cycle.
	logic fall; // Falling bit clock edge seen this cycle.
	logic edge_sh; // Edge that strobes the delay line.
	logic edge_al; // Complementary edge that realigns the inputs.
	logic dl_in; // Bit entering the delay line.
	logic tap_bit; // Selected delay line stage.
	logic ref_a; // Reference presented to the realigning stage.
	logic ref_b; // Reference of comparator B.
	logic b_evt; // Comparator B samples a PCM bit.
	logic mis_b; // Comparator B mismatch.
	logic mis_a; // Comparator A mismatch.

	becp_dly_if dif ();

	becp_var_delay u_var_delay (
		.clk(clk),
		.reset(reset),
		.dif(dif.dly)
	);

	// Edges come from the second synchroniser stage only.
	assign rise = st_reg.s2[P_BCLK] & ~st_reg.clk_d;
	assign fall = ~st_reg.s2[P_BCLK] & st_reg.clk_d;
	// A half-bit setting strobes the line on the inverted clock.
	assign edge_sh = st_reg.dly_half[0] ? fall : rise;
	// Realignment uses the complement of the delay line clock.
	assign edge_al = st_reg.dly_half[0] ? rise : fall;
	// Decoder-output mode feeds the line from the fixed delay on the coder input.
	assign dl_in = st_reg.decoder_delay_mode_switch ?
		st_reg.fix_sr[FIX_LEN-1] : st_reg.s2[P_COUT];
	// Whole bits of the setting pick the stage; the half bit shares it.
	assign tap_bit = st_reg.dline[st_reg.dly_half[3:1]];
	// Decoder-output mode adds the variable delay after the line.
	assign ref_a = st_reg.decoder_delay_mode_switch ? dif.dout : tap_bit;
	// Variable delay advances with the delay line, its length set by the decoder.
	assign dif.shift = edge_sh;
	assign dif.din = tap_bit;
	assign dif.sel = st_reg.s2[P_VSEL+2:P_VSEL];
	// Comparator B reference is the constant level or the external stream.
	assign ref_b = st_reg.b_ext ? st_reg.s2[P_EXT] : st_reg.b_level;
	assign b_evt = rise & st_reg.s2[P_SLOT];
	assign mis_b = st_reg.s2[P_PCM] ^ ref_b;
	assign mis_a = st_reg.vld_a & (st_reg.ref_al ^ st_reg.rx_al);

	// Outputs come straight from the state register.
	assign rdata = st_reg.rdata;
	assign err_a_out = st_reg.div_a[1];
	assign err_b_out = st_reg.err_b;

	// Next state: synchronisers, delay chain, comparators, counters and registers.
	always_comb begin
		st_next = st_reg;
		st_next.s1 = {vit_delay_sel, ext_ref, pcm_slot, pcm_bit, rx_data, coder_in,
			coder_out, bit_clk};
		st_next.s2 = st_reg.s1;
		st_next.clk_d = st_reg.s2[P_BCLK];
		// The fixed delay moves in whole bits.
		if (rise) begin
			st_next.fix_sr = {st_reg.fix_sr[FIX_LEN-2:0], st_reg.s2[P_CIN]};
		end
		// The delay line moves on the chosen clock phase.
		if (edge_sh) begin
			st_next.dline = {st_reg.dline[DLINE_LEN-2:0], dl_in};
		end
		// Both comparator inputs are realigned together.
		if (edge_al) begin
			st_next.ref_al = ref_a;
			st_next.rx_al = st_reg.s2[P_RX];
		end
		st_next.vld_a = edge_al;
		// Each mismatch steps the divider; its top bit toggles every second error.
		if (mis_a) begin
			st_next.div_a = st_reg.div_a + 2'h1;
		end
		// Comparator B reports each mismatch at once, undivided.
		st_next.err_b = b_evt & mis_b;
		// A write to a counter clears it, but an error in the same cycle still counts.
		if (wr && addr == CNT_A_OFS) begin
			st_next.cnt_a = '0;
		end
		if (mis_a) begin
			st_next.cnt_a = (wr && addr == CNT_A_OFS) ? CNT_W'(1) : st_reg.cnt_a + CNT_W'(1);
		end
		if (wr && addr == CNT_B_OFS) begin
			st_next.cnt_b = '0;
		end
		if (b_evt && mis_b) begin
			st_next.cnt_b = (wr && addr == CNT_B_OFS) ? CNT_W'(1) : st_reg.cnt_b + CNT_W'(1);
		end
		// Control register write.
		if (wr && addr == CTRL_OFS) begin
			st_next.dly_half = wdata[DLY_LSB+3:DLY_LSB];
			st_next.decoder_delay_mode_switch = wdata[MODE_BIT];
			st_next.b_level = wdata[BLEVEL_BIT];
			st_next.b_ext = wdata[BEXT_BIT];
		end
		// Read data stand for the one cycle after the strobe; unmapped reads give zero.
		st_next.rdata = '0;
		if (rd) begin
			case (addr)
				CTRL_OFS: begin
					st_next.rdata[DLY_LSB+3:DLY_LSB] = st_reg.dly_half;
					st_next.rdata[MODE_BIT] = st_reg.decoder_delay_mode_switch;
					st_next.rdata[BLEVEL_BIT] = st_reg.b_level;
					st_next.rdata[BEXT_BIT] = st_reg.b_ext;
				end
				CNT_A_OFS: begin
					st_next.rdata[CNT_W-1:0] = st_reg.cnt_a;
				end
				CNT_B_OFS: begin
					st_next.rdata[CNT_W-1:0] = st_reg.cnt_b;
				end
				default: begin
					st_next.rdata = '0;
				end
			endcase
		end
	end

	// State register with constant reset values.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_reg <= '0;
			st_reg.dly_half <= DLY_RST;
			st_reg.decoder_delay_mode_switch <= MODE_RST;
			st_reg.b_level <= BLEVEL_RST;
			st_reg.b_ext <= BEXT_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// A whole-bit setting shifts the line on the rising edge.
	property p_shift_whole;
		(rise && !st_reg.dly_half[0]) |=>
			(st_reg.dline == {$past(st_reg.dline[6:0]), $past(dl_in)});
	endproperty
	a_shift_whole: assert property (p_shift_whole) else $error("line did not shift");

	// A half-bit setting holds the line on the rising edge.
	property p_half_hold;
		(rise && st_reg.dly_half[0]) |=> $stable(st_reg.dline);
	endproperty
	a_half_hold: assert property (p_half_hold) else $error("line moved on wrong phase");

	// In decoder-input mode the realigned reference is the selected stage.
	property p_tap;
		(edge_al && !st_reg.decoder_delay_mode_switch) |=> (st_reg.ref_al == $past(tap_bit));
	endproperty
	a_tap: assert property (p_tap) else $error("wrong delay stage");

	// The received bit is realigned on the complementary edge.
	property p_align;
		edge_al |=> (st_reg.rx_al == $past(st_reg.s2[P_RX])) && st_reg.vld_a;
	endproperty
	a_align: assert property (p_align) else $error("received bit not realigned");

	// A realignment followed by a mismatch steps the divider once.
	sequence s_align_mis;
		edge_al ##1 (st_reg.ref_al != st_reg.rx_al);
	endsequence
	property p_div;
		s_align_mis |=> (st_reg.div_a == $past(st_reg.div_a) + 2'h1);
	endproperty
	a_div: assert property (p_div) else $error("divider missed an error");

	// Without a fresh realigned pair the divider stands still.
	property p_once;
		!st_reg.vld_a |=> $stable(st_reg.div_a);
	endproperty
	a_once: assert property (p_once) else $error("error counted outside bit slot");

	// Each comparator B mismatch gives one pulse of one cycle.
	property p_b_err;
		(b_evt && mis_b) |=> err_b_out ##1 !err_b_out;
	endproperty
	a_b_err: assert property (p_b_err) else $error("B error pulse wrong");

	// With the external reference, matching bits give no error.
	property p_b_ext;
		(b_evt && st_reg.b_ext && st_reg.s2[P_PCM] == st_reg.s2[P_EXT]) |=> !err_b_out;
	endproperty
	a_b_ext: assert property (p_b_ext) else $error("false B error");

	// Without a mismatching comparator B sample the error output stays low.
	property p_b_quiet;
		!(b_evt && mis_b) |=> !err_b_out;
	endproperty
	a_b_quiet: assert property (p_b_quiet) else $error("spurious B error");

	// A PCM bit that differs from the constant level is flagged.
	property p_b_level;
		(b_evt && !st_reg.b_ext && (st_reg.s2[P_PCM] != st_reg.b_level)) |=> err_b_out;
	endproperty
	a_b_level: assert property (p_b_level) else $error("B level error missed");

	// A PCM bit that differs from the external stream is flagged.
	property p_b_ext_mis;
		(b_evt && st_reg.b_ext && (st_reg.s2[P_PCM] != st_reg.s2[P_EXT])) |=> err_b_out;
	endproperty
	a_b_ext_mis: assert property (p_b_ext_mis) else $error("B ext error missed");

	// In decoder-output mode the realigned reference comes from the variable delay.
	property p_ref_out;
		(edge_al && st_reg.decoder_delay_mode_switch) |=> (st_reg.ref_al == $past(dif.dout));
	endproperty
	a_ref_out: assert property (p_ref_out) else $error("wrong reference source");

	// The fixed delay takes one coder input bit on each rising bit clock edge.
	property p_fix;
		rise |=> (st_reg.fix_sr == {$past(st_reg.fix_sr[FIX_LEN-2:0]), $past(st_reg.s2[P_CIN])});
	endproperty
	a_fix: assert property (p_fix) else $error("fixed delay did not shift");

	// The divided output changes only when an odd count steps on, so once per two errors.
	property p_a_pair;
		$changed(err_a_out) |-> $past(st_reg.div_a[0]);
	endproperty
	a_a_pair: assert property (p_a_pair) else $error("A output off pattern");

	// Between realigning edges both comparator inputs hold.
	property p_al_hold;
		!edge_al |=> ($stable(st_reg.rx_al) && $stable(st_reg.ref_al));
	endproperty
	a_al_hold: assert property (p_al_hold) else $error("realigned bit moved");

	// Each comparator A mismatch adds one to its count unless a clear lands with it.
	property p_cnt_a;
		(mis_a && !(wr && addr == CNT_A_OFS)) |=>
			(st_reg.cnt_a == $past(st_reg.cnt_a) + CNT_W'(1));
	endproperty
	a_cnt_a: assert property (p_cnt_a) else $error("A error not counted");

	// Each comparator B mismatch adds one to its count unless a clear lands with it.
	property p_cnt_b;
		(b_evt && mis_b && !(wr && addr == CNT_B_OFS)) |=>
			(st_reg.cnt_b == $past(st_reg.cnt_b) + CNT_W'(1));
	endproperty
	a_cnt_b: assert property (p_cnt_b) else $error("B error not counted");
endmodule : becp_top
`default_nettype wire

// >>> verif/becp_far_model.sv
// Behavioural coder, link and decoder end that feeds the comparator pins.
`timescale 1ns/10ps
`default_nettype none
module becp_far_model (
	input wire logic clk,
	input wire logic [4:0] rx_delay,
	input wire logic rx_from_out,
	input wire logic level,
	input wire logic use_ext,
	input wire logic [2:0] vsel,
	output logic bit_clk,
	output logic coder_out,
	output logic coder_in,
	output logic rx_data,
	output logic pcm_bit,
	output logic pcm_slot,
	output logic ext_ref,
	output logic [2:0] vit_delay_sel
);
	int phase = 0; // Position within the ten-cycle bit period.
	int flips_a = 0; // Received bits still to corrupt.
	int flips_b = 0; // PCM channel bits still to corrupt.
	logic [15:0] lfsr = 16'hace1; // Pattern source for the coder input.
	logic [31:0] hist = 32'h0; // Recent coder input bits, newest at bit 0.
	logic [1:0] slot_cnt = 2'h0; // One bit in four carries the PCM channel.
	initial begin
		{bit_clk, coder_out, coder_in, rx_data, pcm_bit, pcm_slot, ext_ref} = 7'h0;
		vit_delay_sel = 3'h0;
	end
	// Bit clock of ten cycles; data moves two cycles after the falling edge,
	// so both bit clock edges see stable data.
	always @(posedge clk) begin
		phase <= (phase == 9) ? 0 : phase + 1;
		if (phase == 0) bit_clk <= 1'b0;
		if (phase == 5) bit_clk <= 1'b1;
		if (phase == 2) begin
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			hist = {hist[30:0], lfsr[0]};
			slot_cnt = slot_cnt + 2'h1;
			coder_in <= hist[0];
			coder_out <= ~hist[0];
			// The link delays the coder stream by whole bits and may corrupt bits.
			rx_data <= hist[rx_delay] ^ rx_from_out ^ (flips_a > 0);
			if (flips_a > 0) flips_a <= flips_a - 1;
			vit_delay_sel <= vsel;
			pcm_slot <= (slot_cnt == 2'h0);
			ext_ref <= hist[5];
			// The multiplexer puts a constant level, or with use_ext the external reference stream, in the PCM channel.
			pcm_bit <= (use_ext ? hist[5] : level) ^ (slot_cnt == 2'h0 && flips_b > 0);
			if (slot_cnt == 2'h0 && flips_b > 0) flips_b <= flips_b - 1;
		end
	end
endmodule : becp_far_model
`default_nettype wire

// >>> verif/tb_bit_error_comparator_pair.sv
// Self-checking testbench for the bit error comparator pair.
`timescale 1ns/10ps
`default_nettype none
module tb_bit_error_comparator_pair;
	import becp_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic bit_clk, coder_out, coder_in, rx_data, pcm_bit, pcm_slot, ext_ref;
	logic [2:0] vit_delay_sel;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic err_a_out, err_b_out;
	logic [4:0] rx_delay = 5'h0; // Link delay in bits.
	logic rx_from_out = 1'b1; // Link carries the coder output.
	logic level = 1'b0;
	logic use_ext = 1'b0;
	logic [2:0] vsel = 3'h0;
	logic err_a_prev = 1'b0;
	int num_errors = 0;
	int n_compared = 0;
	int toggles = 0; // Changes seen on the divided error output.
	int pulses = 0; // Cycles with the undivided error output high.
	int t;
	becp_top DUT (.clk(clk), .reset(reset), .bit_clk(bit_clk), .coder_out(coder_out),
		.coder_in(coder_in), .rx_data(rx_data), .pcm_bit(pcm_bit), .pcm_slot(pcm_slot),
		.ext_ref(ext_ref), .vit_delay_sel(vit_delay_sel), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .err_a_out(err_a_out), .err_b_out(err_b_out));
	becp_far_model far (.clk(clk), .rx_delay(rx_delay), .rx_from_out(rx_from_out),
		.level(level), .use_ext(use_ext), .vsel(vsel), .bit_clk(bit_clk),
		.coder_out(coder_out), .coder_in(coder_in), .rx_data(rx_data), .pcm_bit(pcm_bit),
		.pcm_slot(pcm_slot), .ext_ref(ext_ref), .vit_delay_sel(vit_delay_sel));
	// The clock runs at 100 MHz.
	initial begin
		forever #5 clk = ~clk;
	end
	// Count changes of the divided output and cycles of the error pulse.
	always @(posedge clk) begin
		if (err_a_out !== err_a_prev) toggles++;
		err_a_prev <= err_a_out;
		if (err_b_out === 1'b1) pulses++;
	end
	// Prints the verdict and ends the run.
	task finish_test;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task bus_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_write
	// Read data stand only in the cycle after the strobe is taken.
	task bus_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : bus_read
	task wait_bits(input int n);
		repeat (n * 10) @(posedge clk);
	endtask : wait_bits
	// Sets comparator A, lets the pipeline settle, then counts output changes.
	task run_a(input logic [3:0] set, input logic mode);
		bus_write(CTRL_OFS, {27'h0, mode, set});
		wait_bits(50);
		toggles = 0;
		wait_bits(40);
		t = toggles;
	endtask : run_a
	task s_regs;
		logic [31:0] d;
		bus_read(CTRL_OFS, d);
		check("ctrl after reset", 32'h0, d);
		bus_write(CTRL_OFS, 32'h7f);
		bus_read(CTRL_OFS, d);
		check("ctrl written", 32'h7f, d);
		bus_read(8'h10, d);
		check("unmapped read", 32'h0, d);
		bus_write(CTRL_OFS, 32'h0);
	endtask : s_regs
	// A three-bit link delay matches settings of three bits and two and a half bits only.
	task s_align;
		rx_from_out <= 1'b1;
		rx_delay <= 5'h3;
		run_a(4'h6, 1'b0);
		check("errors at 3 bits", 32'h0, t);
		run_a(4'h5, 1'b0);
		check("errors at 2.5 bits", 32'h0, t);
		run_a(4'h0, 1'b0);
		check("errors at 0 bits seen", 32'h1, 32'(t > 0));
	endtask : s_align
	// Decoder-output mode: fixed delay plus four bits per select step.
	task s_mode;
		rx_from_out <= 1'b0;
		rx_delay <= 5'(FIX_LEN + 2 * VAR_STEP);
		vsel <= 3'h2;
		run_a(4'h0, 1'b1);
		check("errors at matched select", 32'h0, t);
		vsel <= 3'h1;
		run_a(4'h0, 1'b1);
		check("errors at wrong select seen", 32'h1, 32'(t > 0));
	endtask : s_mode
	// After reset three errors give one change, a fourth gives the second.
	// The mid-run reset also returns the control register to decoder-input mode.
	task s_div;
		logic [31:0] d;
		rx_from_out <= 1'b1;
		rx_delay <= 5'h0;
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		bus_read(CTRL_OFS, d);
		check("ctrl after mid-run reset", 32'h0, d);
		wait_bits(20);
		toggles = 0;
		@(negedge clk) far.flips_a = 3;
		wait_bits(10);
		check("changes after 3 errors", 32'h1, toggles);
		@(negedge clk) far.flips_a = 1;
		wait_bits(10);
		check("changes after 4 errors", 32'h2, toggles);
		bus_read(CNT_A_OFS, d);
		check("A error count", 32'h4, d);
	endtask : s_div
	// Comparator B against level zero, level one and the external stream.
	task s_b;
		logic [31:0] d;
		for (int i = 0; i < 3; i++) begin
			bus_write(CTRL_OFS, {25'h0, i == 2, i == 1, 5'h0});
			level <= (i == 1);
			use_ext <= (i == 2);
			wait_bits(8);
			bus_write(CNT_B_OFS, 32'h0);
			pulses = 0;
			@(negedge clk) far.flips_b = 5;
			wait_bits(40);
			check("error pulses", 32'h5, pulses);
			bus_read(CNT_B_OFS, d);
			check("error count", 32'h5, d);
		end
	endtask : s_b
	// Main sequence: ten cycles of reset, then the scenarios.
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		s_regs;
		s_align;
		s_mode;
		s_div;
		s_b;
		finish_test;
	end
	// Watchdog well beyond the expected run of about 6400 cycles.
	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		finish_test;
	end
endmodule : tb_bit_error_comparator_pair
`default_nettype wire
